// >>> pkg/meas_bank_cfg.svh
`ifndef MEAS_BANK_CFG_SVH
`define MEAS_BANK_CFG_SVH

// register offsets (word addresses on the register port)
`define OFS_CELL_FIRST   6'h19
`define OFS_CELL_LAST    6'h24
`define OFS_SEC_HIGH     6'h25
`define OFS_SEC_LOW      6'h26
`define OFS_STRESS       6'h27
`define OFS_BLOCK        6'h28
`define OFS_EXT_FIRST    6'h29
`define OFS_EXT3         6'h2c
`define OFS_EXT4         6'h2d
`define OFS_RDIAG        6'h2f
`define OFS_DIE          6'h30
`define OFS_TRIGGER      6'h31
`define OFS_SELECTION    6'h32
`define OFS_OVERCURRENT  6'h33
`define OFS_UNDERCURRENT 6'h34

// result register fields
`define RES_LSB          0
`define RES_MSB          9
`define SRC_LSB          10
`define SRC_MSB          11
`define SINK_BIT         12
`define VALID_BIT        13
`define FAULT_BIT        14

// selection register fields
`define SEL_CELL_LSB     0
`define SEL_CELL_MSB     3
`define SEL_BLOCK_BIT    4
`define SEL_EXT_LSB      5
`define SEL_EXT_MSB      7
`define SEL_RDIAG_BIT    8
`define SEL_DIE_BIT      9
`define SEL_SEC_BIT      10
`define SEL_STRESS_BIT   11
`define SEL_WIDTH        12

// counts and reset values
`define CELL_COUNT       12
`define CELL_CODE_MAX    4'hc
`define EXT_CODE_MAX     3'h5
`define RESET_WORD       16'h0000

`endif

// >>> pkg/meas_bank_pkg.sv
`default_nettype none
package meas_bank_pkg;

  // burst read sequencer
  typedef enum logic {
    burst_idle,
    burst_run
  } burst_state_t;

  typedef logic [5:0]  reg_addr_t;
  typedef logic [15:0] reg_word_t;

endpackage
`default_nettype wire

// >>> rtl/meas_result_multiread_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "meas_bank_cfg.svh"

// Functional notes
// - external sensor results keep the converter value in bits 9:0.
// - bits 11:10 report which of four sensor sources was active.
// - bit 12 set when the mux-test sink switch was active.
// - valid bit sets on a new result, clears when the register is read.
// - sink fault clears on write, or on general diagnostics fault clear.
// - diag resistor result: value, source number, and source 0/1 bit.
// - die thermal register: value in bits 9:0, valid self-clears on read.
// - reading the trigger register starts a burst of the selected results.
// - cell code 0 none, n=1..12 cells 11 down to 12-n, above none.
// - block voltage select one includes the block voltage result.
// - external code n=1..5 includes sensors 0 to n-1, zero none.
// - diag resistor select bit set includes the diag resistor result.
// - die thermal select one includes the die thermal result.
// - secondary select one includes highest and lowest secondary results.
// - stress select one includes the primary stress correction value.
// - cell overcurrent sets its flag and stops balancing that cell.
// - cell undercurrent sets its flag and stops balancing that cell.
// - balance flags clear on write or on general diagnostics bit clear.
module meas_result_multiread_bank (
  input  wire logic        core_clk,       // device clock, 50 MHz
  input  wire logic        sys_rst,        // synchronous reset, active high
  input  wire logic        reg_rd,         // register read pulse
  input  wire logic        reg_wr,         // register write pulse
  input  wire logic        reg_bcast,      // write came as broadcast
  input  wire logic [5:0]  reg_addr,       // register address
  input  wire logic [15:0] reg_wdata,      // write data
  output logic      [15:0] reg_rdata,      // read data, registered
  output logic             reg_rvalid,     // read answer pulse
  input  wire logic        ext3_upd,       // new sensor 3 result
  input  wire logic [12:0] ext3_data,      // sink, source, value
  input  wire logic        ext3_fault,     // sensor 3 sink fault event
  input  wire logic        ext4_upd,       // new sensor 4 result
  input  wire logic [12:0] ext4_data,      // sink, source, value
  input  wire logic        ext4_fault,     // sensor 4 sink fault event
  input  wire logic        rdiag_upd,      // new diag resistor result
  input  wire logic [12:0] rdiag_data,     // source bit, source, value
  input  wire logic        die_upd,        // new die thermal result
  input  wire logic [9:0]  die_data,       // die thermal value
  input  wire logic [11:0] oc_det,         // overcurrent event per cell
  input  wire logic [11:0] uc_det,         // undercurrent event per cell
  input  wire logic        ext_fault_clr,  // zero written to sensor fault bit
  input  wire logic        oc_diag_clr,    // zero written to overcurrent bit
  input  wire logic        uc_diag_clr,    // zero written to undercurrent bit
  output logic      [11:0] bal_inhibit,    // balancing stopped per cell
  output logic             burst_busy,     // burst in progress
  output logic             burst_req,      // burst word pulse
  output logic      [5:0]  burst_addr,     // address of burst word
  output logic      [15:0] burst_data,     // burst word data
  output logic             burst_last,     // end of walk pulse
  input  wire logic [15:0] ext_rdata       // outer data at the cursor address
);

  // ==========================================================
  // burst selection decode
  // ==========================================================

  // true when address a belongs to the burst chosen by cfg
  function automatic logic burst_incl(input logic [5:0] a,
                                      input logic [11:0] cfg);
    logic [3:0] nc;
    logic [2:0] ne;
    logic [5:0] rel;
    begin
      nc = cfg[`SEL_CELL_MSB:`SEL_CELL_LSB];
      ne = cfg[`SEL_EXT_MSB:`SEL_EXT_LSB];
      burst_incl = 1'b0;
      if (a >= `OFS_CELL_FIRST && a <= `OFS_CELL_LAST) begin
        rel = a - `OFS_CELL_FIRST;
        // codes above twelve select no cells
        if (nc != 4'h0 && nc <= `CELL_CODE_MAX) begin
          burst_incl = ({2'b00, rel} >= (6'd12 - {2'b00, nc}));
        end
      end else if (a == `OFS_SEC_HIGH || a == `OFS_SEC_LOW) begin
        burst_incl = cfg[`SEL_SEC_BIT];
      end else if (a == `OFS_STRESS) begin
        burst_incl = cfg[`SEL_STRESS_BIT];
      end else if (a == `OFS_BLOCK) begin
        burst_incl = cfg[`SEL_BLOCK_BIT];
      end else if (a >= `OFS_EXT_FIRST && a <= `OFS_EXT4) begin
        rel = a - `OFS_EXT_FIRST;
        // codes six and seven are undefined, treated as none
        if (ne <= `EXT_CODE_MAX) begin
          burst_incl = (rel[2:0] < ne);
        end
      end else if (a == `OFS_RDIAG) begin
        burst_incl = cfg[`SEL_RDIAG_BIT];
      end else if (a == `OFS_DIE) begin
        burst_incl = cfg[`SEL_DIE_BIT];
      end
    end
  endfunction

  // ==========================================================
  // state
  // ==========================================================

  logic [12:0] ext3_q;
  logic [12:0] ext4_q;
  logic        ext3_valid_q;
  logic        ext4_valid_q;
  logic        ext3_fault_q;
  logic        ext4_fault_q;
  logic [12:0] rdiag_q;
  logic        rdiag_valid_q;
  logic [9:0]  die_q;
  logic        die_valid_q;
  logic [11:0] sel_q;
  logic [11:0] oc_q;
  logic [11:0] uc_q;
  meas_bank_pkg::burst_state_t state_q;
  logic [5:0]  cur_q;
  logic        emit;
  logic        start;

  // read strobe for one address: host read or burst return
  function automatic logic hit(input logic [5:0] a, input logic rd,
                               input logic [5:0] ra, input logic em,
                               input logic [5:0] ca);
    begin
      hit = (rd && ra == a) || (em && ca == a);
    end
  endfunction

  function automatic logic wr_hit(input logic w, input logic [5:0] ra,
                                  input logic [5:0] a);
    begin
      wr_hit = w && ra == a;
    end
  endfunction

  // ==========================================================
  // burst sequencer
  // ==========================================================

  // one address per cycle; the walk always covers the whole window
  assign start = reg_rd && reg_addr == `OFS_TRIGGER &&
                 state_q == meas_bank_pkg::burst_idle;
  assign emit  = state_q == meas_bank_pkg::burst_run &&
                 burst_incl(cur_q, sel_q);
  assign burst_busy = state_q == meas_bank_pkg::burst_run;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= meas_bank_pkg::burst_idle;
      cur_q   <= `OFS_CELL_FIRST;
    end else begin
      case (state_q)
        meas_bank_pkg::burst_idle: begin
          cur_q <= `OFS_CELL_FIRST;
          if (start) begin
            state_q <= meas_bank_pkg::burst_run;
          end
        end
        meas_bank_pkg::burst_run: begin
          cur_q <= cur_q + 6'h01;
          if (cur_q == `OFS_DIE) begin
            state_q <= meas_bank_pkg::burst_idle;
          end
        end
        default: state_q <= meas_bank_pkg::burst_idle;
      endcase
    end
  end

  // ==========================================================
  // external sensor results 3 and 4
  // ==========================================================

  // value, source and sink state are stored as one word
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext3_q <= 13'h0000;
      ext4_q <= 13'h0000;
    end else begin
      if (ext3_upd) begin
        ext3_q <= ext3_data;
      end
      if (ext4_upd) begin
        ext4_q <= ext4_data;
      end
    end
  end

  // valid: new result wins over a read in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext3_valid_q <= 1'b0;
      ext4_valid_q <= 1'b0;
    end else begin
      if (ext3_upd) begin
        ext3_valid_q <= 1'b1;
      end else if (hit(`OFS_EXT3, reg_rd, reg_addr, emit, cur_q)) begin
        ext3_valid_q <= 1'b0;
      end
      if (ext4_upd) begin
        ext4_valid_q <= 1'b1;
      end else if (hit(`OFS_EXT4, reg_rd, reg_addr, emit, cur_q)) begin
        ext4_valid_q <= 1'b0;
      end
    end
  end

  // sink fault: set wins over write clear and diagnostics clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ext3_fault_q <= 1'b0;
      ext4_fault_q <= 1'b0;
    end else begin
      if (ext3_fault) begin
        ext3_fault_q <= 1'b1;
      end else if (wr_hit(reg_wr, reg_addr, `OFS_EXT3) || ext_fault_clr) begin
        ext3_fault_q <= 1'b0;
      end
      if (ext4_fault) begin
        ext4_fault_q <= 1'b1;
      end else if (wr_hit(reg_wr, reg_addr, `OFS_EXT4) || ext_fault_clr) begin
        ext4_fault_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // diag resistor and die thermal results
  // ==========================================================

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdiag_q <= 13'h0000;
      die_q   <= 10'h000;
    end else begin
      if (rdiag_upd) begin
        rdiag_q <= rdiag_data;
      end
      if (die_upd) begin
        die_q <= die_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdiag_valid_q <= 1'b0;
      die_valid_q   <= 1'b0;
    end else begin
      if (rdiag_upd) begin
        rdiag_valid_q <= 1'b1;
      end else if (hit(`OFS_RDIAG, reg_rd, reg_addr, emit, cur_q)) begin
        rdiag_valid_q <= 1'b0;
      end
      if (die_upd) begin
        die_valid_q <= 1'b1;
      end else if (hit(`OFS_DIE, reg_rd, reg_addr, emit, cur_q)) begin
        die_valid_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // selection register
  // ==========================================================

  // addressed writes are dropped so all nodes share one selection
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sel_q <= 12'h000;
    end else if (wr_hit(reg_wr, reg_addr, `OFS_SELECTION) && reg_bcast) begin
      sel_q <= reg_wdata[`SEL_WIDTH-1:0];
    end
  end

  // ==========================================================
  // balancing diagnostics
  // ==========================================================

  // any write clears the whole register; a new event still wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      oc_q <= 12'h000;
    end else if (wr_hit(reg_wr, reg_addr, `OFS_OVERCURRENT) || oc_diag_clr) begin
      oc_q <= oc_det;
    end else begin
      oc_q <= oc_q | oc_det;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      uc_q <= 12'h000;
    end else if (wr_hit(reg_wr, reg_addr, `OFS_UNDERCURRENT) || uc_diag_clr) begin
      uc_q <= uc_det;
    end else begin
      uc_q <= uc_q | uc_det;
    end
  end

  // balancing stays off for a flagged cell until its flag clears
  assign bal_inhibit = oc_q | uc_q;

  // ==========================================================
  // read data
  // ==========================================================

  // view of one address as software sees it
  function automatic logic [15:0] view(input logic [5:0] a,
                                       input logic [15:0] ext_w);
    begin
      case (a)
        `OFS_EXT3: view = {1'b0, ext3_fault_q, ext3_valid_q, ext3_q};
        `OFS_EXT4: view = {1'b0, ext4_fault_q, ext4_valid_q, ext4_q};
        `OFS_RDIAG: view = {2'b00, rdiag_valid_q, rdiag_q};
        `OFS_DIE: view = {2'b00, die_valid_q, 3'b000, die_q};
        `OFS_SELECTION: view = {4'h0, sel_q};
        `OFS_OVERCURRENT: view = {4'h0, oc_q};
        `OFS_UNDERCURRENT: view = {4'h0, uc_q};
        // trigger register reads zero; other addresses return ext_w, which is zero on host reads
        `OFS_TRIGGER: view = `RESET_WORD;
        default: view = ext_w;
      endcase
    end
  endfunction

  // host read answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata  <= `RESET_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= view(reg_addr, `RESET_WORD);
      end
    end
  end

  // burst words; addresses outside the bank take the outer data
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      burst_req  <= 1'b0;
      burst_addr <= 6'h00;
      burst_data <= `RESET_WORD;
      burst_last <= 1'b0;
    end else begin
      burst_req  <= emit;
      burst_last <= state_q == meas_bank_pkg::burst_run && cur_q == `OFS_DIE;
      if (emit) begin
        burst_addr <= cur_q;
        burst_data <= view(cur_q, ext_rdata);
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/meas_bank_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// result bank port checker
module meas_bank_checker (
  input wire logic        core_clk,      // clock
  input wire logic        sys_rst,       // sync reset
  input wire logic        reg_rd,        // read pulse
  input wire logic [5:0]  reg_addr,      // address
  input wire logic [15:0] reg_rdata,     // read data
  input wire logic        ext3_upd,      // new sensor 3 result
  input wire logic [12:0] ext3_data,     // sensor 3 result
  input wire logic        die_upd,       // new die result
  input wire logic [9:0]  die_data,      // die result
  input wire logic [11:0] oc_det,        // overcurrent events
  input wire logic [11:0] uc_det,        // undercurrent events
  input wire logic        oc_diag_clr,   // overcurrent clear
  input wire logic        uc_diag_clr,   // undercurrent clear
  input wire logic [11:0] bal_inhibit,   // balancing stopped
  input wire logic        burst_busy,    // walk running
  input wire logic        burst_req,     // burst word
  input wire logic [5:0]  burst_addr,    // burst word address
  input wire logic        burst_last     // walk done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic seen_q; // sensor 3 read since its last update
  // a fresh result wins, so valid must show again
  always_ff @(posedge core_clk) begin
    if (sys_rst || ext3_upd) seen_q <= 1'h0;
    else if (reg_rd && reg_addr == 6'h2c) seen_q <= 1'h1;
  end
  // ==========
  // properties
  property p_valid_clear;
    reg_rd && reg_addr == 6'h2c && seen_q && !ext3_upd |=> !reg_rdata[13];
  endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("valid kept after read");
  property p_ext_result;
    ext3_upd ##1 !ext3_upd ##1 (reg_rd && reg_addr == 6'h2c && !ext3_upd)
      |=> reg_rdata[13:0] == {1'h1, $past(ext3_data, 3)};
  endproperty
  a_ext_result: assert property (p_ext_result)
    else $error("sensor word wrong");
  property p_die;
    die_upd ##1 !die_upd ##1 (reg_rd && reg_addr == 6'h30 && !die_upd)
      |=> reg_rdata == {6'h08, $past(die_data, 3)};
  endproperty
  a_die: assert property (p_die) else $error("die word wrong");
  property p_oc_set;
    oc_det != 12'h0 |=> (bal_inhibit & $past(oc_det)) == $past(oc_det);
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("overcurrent not latched");
  property p_uc_set;
    uc_det != 12'h0 |=> (bal_inhibit & $past(uc_det)) == $past(uc_det);
  endproperty
  a_uc_set: assert property (p_uc_set) else $error("undercurrent not latched");
  property p_flag_clr;
    oc_diag_clr && uc_diag_clr && oc_det == 12'h0 && uc_det == 12'h0 |=> bal_inhibit == 12'h0;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");
  property p_burst_len;
    reg_rd && reg_addr == 6'h31 && !burst_busy
      |=> burst_busy [*8] ##16 (burst_busy && !burst_last) ##1 (burst_last && !burst_busy);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("walk length wrong");
  property p_order;
    burst_req ##1 burst_req |-> burst_addr > $past(burst_addr);
  endproperty
  a_order: assert property (p_order) else $error("burst out of order");
endmodule

bind meas_result_multiread_bank meas_bank_checker u_chk (.core_clk, .sys_rst, .reg_rd,
  .reg_addr, .reg_rdata, .ext3_upd, .ext3_data, .die_upd, .die_data, .oc_det, .uc_det,
  .oc_diag_clr, .uc_diag_clr, .bal_inhibit, .burst_busy, .burst_req, .burst_addr,
  .burst_last);
`default_nettype wire

// >>> tb/meas_outer_regs.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// results held outside the bank
module meas_outer_regs (
  input  wire logic        core_clk,   // clock
  input  wire logic        sys_rst,    // sync reset
  input  wire logic        burst_busy, // walk running
  output logic      [15:0] ext_rdata   // word for cursor
);
  logic [5:0] step_q; // cycles since the walk began
  // cursor is not exported, so it is rebuilt from busy
  always_ff @(posedge core_clk) begin
    if (sys_rst || !burst_busy) step_q <= 6'h0;
    else step_q <= step_q + 6'h1;
  end
  // idle word is inverted so stale data never passes
  assign ext_rdata = burst_busy ? {10'h2c3, 6'h19 + step_q} : ~{10'h2c3, 6'h19 + step_q};
endmodule
`default_nettype wire

// >>> tb/meas_result_multiread_bank_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module meas_result_multiread_bank_tb_top;
  // ==========
  // signals
  logic core_clk = 1'h0, sys_rst = 1'h1, reg_rd = 1'h0, reg_wr = 1'h0, reg_bcast = 1'h0;
  logic [5:0] reg_addr = 6'h0, burst_addr, ra[9];
  logic [15:0] reg_wdata = 16'h0, reg_rdata, ext_rdata, burst_data;
  logic reg_rvalid, burst_busy, burst_req, burst_last;
  logic [11:0] bal_inhibit, oc_det = 12'h0, uc_det = 12'h0, cf[5];
  logic [12:0] ext3_data = 13'h0, ext4_data = 13'h0, rdiag_data = 13'h0;
  logic [9:0] die_data = 10'h0;
  logic [8:0] evt = 9'h0;
  wire ext3_upd, ext4_upd, ext3_fault, ext4_fault, rdiag_upd, die_upd;
  wire ext_fault_clr, oc_diag_clr, uc_diag_clr;
  int errors = 0, cmp_count = 0, i, a;
  logic [5:0] qa[$], xa[$];
  logic [15:0] qd[$];
  assign {ext3_upd, ext4_upd, ext3_fault, ext4_fault, rdiag_upd, die_upd, ext_fault_clr,
          oc_diag_clr, uc_diag_clr} = evt;
  meas_result_multiread_bank dut (.core_clk, .sys_rst, .reg_rd, .reg_wr, .reg_bcast,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .ext3_upd, .ext3_data, .ext3_fault,
    .ext4_upd, .ext4_data, .ext4_fault, .rdiag_upd, .rdiag_data, .die_upd, .die_data,
    .oc_det, .uc_det, .ext_fault_clr, .oc_diag_clr, .uc_diag_clr, .bal_inhibit,
    .burst_busy, .burst_req, .burst_addr, .burst_data, .burst_last, .ext_rdata);
  meas_outer_regs u_outer (.core_clk, .sys_rst, .burst_busy, .ext_rdata);
  initial forever #10 core_clk = ~core_clk;
  // collect burst words where they are settled
  always @(negedge core_clk) if (burst_req === 1'h1) begin
    qa.push_back(burst_addr);
    qd.push_back(burst_data);
  end
  // ==========
  // tasks
  task automatic chk(input logic [15:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("Error at %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic wr(input logic [5:0] ad, input logic [15:0] d, input logic b);
    @(negedge core_clk);
    {reg_wr, reg_addr, reg_wdata, reg_bcast} = {1'h1, ad, d, b};
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input logic [5:0] ad, input logic [15:0] e);
    int n;
    @(negedge core_clk);
    {reg_rd, reg_addr} = {1'h1, ad};
    @(negedge core_clk);
    reg_rd = 1'h0;
    for (n = 0; n < 4 && reg_rvalid !== 1'h1; n++) @(negedge core_clk);
    if (n == 4) hang();
    chk(reg_rdata, e);
  endtask
  // one-cycle event pulses on the measurement side
  task automatic ev(input logic [8:0] e, input logic [11:0] o = 12'h0, u = 12'h0);
    @(negedge core_clk);
    {evt, oc_det, uc_det} = {e, o, u};
    @(negedge core_clk);
    {evt, oc_det, uc_det} = '0;
  endtask
  function automatic bit sel(logic [11:0] c, int a);
    int n = c[3:0];
    int e = c[7:5];
    if (a <= 6'h24) return n > 0 && n < 13 && a - 6'h19 >= 12 - n;
    if (a == 6'h25 || a == 6'h26) return c[10];
    if (a == 6'h27) return c[11];
    if (a == 6'h28) return c[4];
    if (a <= 6'h2d) return e < 6 && a - 6'h29 < e;
    if (a == 6'h2f) return c[8];
    return a == 6'h30 && c[9];
  endfunction
  // selection is always sent as broadcast here
  task automatic burst(input logic [11:0] c);
    int n;
    wr(6'h32, {4'h0, c}, 1'h1);
    qa.delete();
    qd.delete();
    xa.delete();
    rd(6'h31, 16'h0);
    for (n = 0; n < 40 && burst_last !== 1'h1; n++) @(negedge core_clk);
    if (n == 40) hang();
    @(negedge core_clk);
    for (a = 6'h19; a <= 6'h30; a++) if (sel(c, a)) xa.push_back(6'(a));
    chk(16'(qa.size()), 16'(xa.size()));
    foreach (xa[k]) begin
      chk({10'h0, qa[k]}, {10'h0, xa[k]});
      if (xa[k] < 6'h2c) chk(qd[k], {10'h2c3, xa[k]});
      if (xa[k] == 6'h2c) chk(qd[k], 16'h1a5a);
      if (xa[k] == 6'h30) chk(qd[k], 16'h22aa);
    end
  endtask
  // ==========
  // main sequence
  initial begin
    ra = '{6'h2c, 6'h2d, 6'h2f, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h3f};
    cf = '{12'h000, 12'h03c, 12'h021, 12'h4e1, 12'hfad};
    repeat (8) @(negedge core_clk);
    sys_rst = 1'h0;
    foreach (ra[k]) rd(ra[k], 16'h0);
    ext3_data = 13'h1a5a;
    ev(9'h100);
    rd(6'h2c, 16'h3a5a);
    rd(6'h2c, 16'h1a5a);
    ev(9'h040);
    rd(6'h2c, 16'h5a5a);
    wr(6'h2c, 16'h0, 1'h0);
    rd(6'h2c, 16'h1a5a);
    // every source code on sensor 4
    for (i = 0; i < 4; i++) begin
      ext4_data = {1'h0, 2'(i), 10'h3c0 + 10'(i)};
      ev(9'h080);
      rd(6'h2d, {3'h1, ext4_data});
    end
    ev(9'h020);
    rd(6'h2d, {3'h2, ext4_data});
    ev(9'h004);
    rd(6'h2d, {3'h0, ext4_data});
    rdiag_data = 13'h1c01;
    ev(9'h010);
    rd(6'h2f, 16'h3c01);
    die_data = 10'h2aa;
    ev(9'h008);
    rd(6'h30, 16'h22aa);
    rd(6'h30, 16'h02aa);
    wr(6'h32, 16'hffff, 1'h0);
    rd(6'h32, 16'h0);
    ev(9'h008);
    foreach (cf[k]) burst(cf[k]);
    rd(6'h30, 16'h02aa);
    ev(9'h0, 12'h801);
    chk({4'h0, bal_inhibit}, 16'h0801);
    rd(6'h33, 16'h0801);
    ev(9'h0, 12'h0, 12'h002);
    chk({4'h0, bal_inhibit}, 16'h0803);
    rd(6'h34, 16'h0002);
    wr(6'h33, 16'h0, 1'h0);
    chk({4'h0, bal_inhibit}, 16'h0002);
    ev(9'h001);
    chk({4'h0, bal_inhibit}, 16'h0);
    ev(9'h0, 12'h00f);
    ev(9'h002);
    chk({4'h0, bal_inhibit}, 16'h0);
    ev(9'h0, 12'hfff, 12'hfff);
    ev(9'h003);
    chk({4'h0, bal_inhibit}, 16'h0);
    stop_test();
  end
endmodule
`default_nettype wire
